//--- include/pmsr_pkg.sv
package pmsr_pkg;
  // widths of the register port and of the phy register space
  localparam int REG_AW = 5;
  localparam int CTL_DW = 8;
  localparam int PHY_DW = 16;
  // control space indices seen on the register port
  localparam logic [4:0] CTL_MGMT_CMD = 5'h02;
  localparam logic [4:0] CTL_PHY_SEL = 5'h04;
  localparam logic [4:0] CTL_RDATA_LO = 5'h08;
  localparam logic [4:0] CTL_RDATA_HI = 5'h09;
  localparam logic [4:0] CTL_MGMT_STAT = 5'h0a;
  localparam logic [4:0] CTL_SIL_REV = 5'h12;
  // phy register space addresses
  localparam logic [4:0] PHY_CTL_ONE = 5'h00;
  localparam logic [4:0] PHY_STAT_ONE = 5'h01;
  localparam logic [4:0] PHY_IDENT_HI = 5'h02;
  localparam logic [4:0] PHY_IDENT_LO = 5'h03;
  localparam logic [4:0] PHY_STAT_TWO = 5'h11;
  localparam logic [4:0] PHY_LED_CTL = 5'h14;
  // mgmt_command and mgmt_status bit positions
  localparam int CMD_SINGLE_BIT = 0;
  localparam int CMD_SCAN_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SCAN_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  // phy_status_one bit positions
  localparam int S1_FDPX_BIT = 12;
  localparam int S1_HDPX_BIT = 11;
  localparam int S1_LINK_BIT = 2;
  localparam int S1_JAB_BIT = 1;
  // phy_status_two bit positions
  localparam int S2_TX_BIT = 13;
  localparam int S2_RX_BIT = 12;
  localparam int S2_COL_BIT = 11;
  localparam int S2_LINK_BIT = 10;
  localparam int S2_DPX_BIT = 9;
  localparam int S2_POL_BIT = 5;
  // duplex configuration bit in phy_control_one
  localparam int CTL1_DPX_BIT = 8;
  // reset values
  localparam logic [15:0] LED_CTL_RESET = 16'h3422;
  // timing: one management read cycle takes at least this long
  localparam int CLK_PERIOD_NS = 20;
  localparam int MII_READ_NS = 2560;
  localparam int MII_READ_CYCLES = (MII_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // management engine states
  typedef enum logic [1:0] {
    PMSR_IDLE = 2'b01,
    PMSR_READ = 2'b10
  } pmsr_state_type;
endpackage : pmsr_pkg

//--- verilog/pmsr_mii_reader.sv
`timescale 1ns/1ps
module pmsr_mii_reader
  import pmsr_pkg::*;
#(
  parameter int READ_CYCLES = MII_READ_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // commands
  input wire logic start_single,
  input wire logic scan_en,
  input wire logic [REG_AW-1:0] reg_sel,
  // phy register file, addressed by addr
  output logic [REG_AW-1:0] addr,
  input wire logic [PHY_DW-1:0] rd_in,
  // results and status
  output logic sample,
  output logic [PHY_DW-1:0] data,
  output logic busy,
  output logic scan_active,
  output logic pending
);
  localparam int CW = $clog2(READ_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(READ_CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  pmsr_state_type state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt; // cycles spent in this read
  logic [REG_AW-1:0] addr_ff, nxt_addr; // address frozen per read
  logic [PHY_DW-1:0] data_ff, nxt_data;
  logic scan_ff, nxt_scan;
  logic pend_ff, nxt_pend;

  assign addr = addr_ff;
  assign data = data_ff;
  assign busy = (state_ff == PMSR_READ);
  assign scan_active = scan_ff;
  assign pending = pend_ff;
  // sample strobe is combinational so the caller can clear latches in the same edge
  assign sample = (state_ff == PMSR_READ) && (cnt_ff == LAST);

  // next state: a read starts from idle only, scan restarts after one idle cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_scan = scan_ff;
    nxt_pend = pend_ff;
    unique case (state_ff)
      PMSR_IDLE: begin
        // scan_active stays low once the command is gone and no read runs
        nxt_scan = scan_en;
        if (scan_en || start_single) begin
          nxt_state = PMSR_READ;
          nxt_cnt = ZERO;
          nxt_addr = reg_sel;
          // only a fresh command marks the data as stale
          if (start_single || !scan_ff) begin
            nxt_pend = 1'b1;
          end
        end
      end
      PMSR_READ: begin
        if (scan_en) begin
          nxt_scan = 1'b1;
        end
        if (sample) begin
          nxt_data = rd_in;
          nxt_pend = 1'b0;
          nxt_state = PMSR_IDLE;
          // scan status falls with the last read once the scan bit is gone,
          // so the idle cycle after it never shows a stale scan
          nxt_scan = scan_en;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    endcase
  end

  // register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= PMSR_IDLE;
      cnt_ff <= ZERO;
      addr_ff <= '0;
      data_ff <= '0;
      scan_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      scan_ff <= nxt_scan;
      pend_ff <= nxt_pend;
    end
  end
endmodule : pmsr_mii_reader

//--- verilog/pmsr_top.sv
`timescale 1ns/1ps
module pmsr_top
  import pmsr_pkg::*;
#(
  parameter int READ_CYCLES = MII_READ_CYCLES,
  parameter logic [21:0] PHY_OUI_BITS = 22'h05a5a5, // arbitrary value
  parameter logic [5:0] PHY_PART = 6'h15, // arbitrary value
  parameter logic [3:0] PHY_REV = 4'h3, // arbitrary value
  parameter logic [4:0] SIL_REV = 5'h07 // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // control register port from the serial command decoder
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [REG_AW-1:0] REG_ADDR,
  input wire logic [CTL_DW-1:0] REG_WDATA,
  output logic [CTL_DW-1:0] REG_RDATA,
  // phy register writes from the neighbouring write engine
  input wire logic PHY_WR_STB,
  input wire logic [REG_AW-1:0] PHY_WR_ADDR,
  input wire logic [PHY_DW-1:0] PHY_WR_DATA,
  input wire logic PHY_WR_BUSY,
  // live phy conditions
  input wire logic LINK_UP,
  input wire logic JABBER_DETECT,
  input wire logic PHY_TX_ACTIVE,
  input wire logic PHY_RX_ACTIVE,
  input wire logic COLLISION,
  input wire logic RX_POL_INVERTED,
  input wire logic LED_B_STRAP,
  // configuration outputs
  output logic [PHY_DW-1:0] LED_CONTROL,
  output logic DUPLEX_STATE
);
  // control registers
  logic [1:0] cmd_ff, nxt_cmd; // continuous_scan_enable, single_read_enable
  logic [REG_AW-1:0] sel_ff, nxt_sel; // phy_reg_select
  logic [PHY_DW-1:0] led_ff, nxt_led; // led_control
  logic dpx_ff, nxt_dpx; // duplex bit of phy_control_one
  logic strap_ff, nxt_strap; // strap not yet captured
  // latching status bits
  logic llink_ff, nxt_llink;
  logic ljab_ff, nxt_ljab;
  // read data
  logic [CTL_DW-1:0] rdata_ff, nxt_rdata;

  // engine wiring
  logic start_single;
  logic [REG_AW-1:0] eng_addr;
  logic [PHY_DW-1:0] eng_rd_in;
  logic eng_sample;
  logic [PHY_DW-1:0] eng_data;
  logic eng_busy;
  logic eng_scan;
  logic eng_pend;
  logic stat_one_read; // sample of phy_status_one this cycle
  logic [PHY_DW-1:0] stat_one;
  logic [PHY_DW-1:0] stat_two;
  logic [CTL_DW-1:0] mgmt_stat;

  // a write is a command write when it hits this index
  function automatic logic hit(input logic strobe, input logic [REG_AW-1:0] a,
                               input logic [REG_AW-1:0] want);
    hit = strobe && (a == want);
  endfunction : hit

  // start one read
  // a single read starts only on the 0 to 1 edge of the bit
  assign start_single = hit(REG_WR, REG_ADDR, CTL_MGMT_CMD) &&
                        REG_WDATA[CMD_SINGLE_BIT] && !cmd_ff[CMD_SINGLE_BIT];

  pmsr_mii_reader #(
    .READ_CYCLES(READ_CYCLES)
  ) u_reader (
    .clk(CLOCK),
    .srst(SRST),
    .start_single(start_single),
    .scan_en(cmd_ff[CMD_SCAN_BIT]),
    .reg_sel(sel_ff),
    .addr(eng_addr),
    .rd_in(eng_rd_in),
    .sample(eng_sample),
    .data(eng_data),
    .busy(eng_busy),
    .scan_active(eng_scan),
    .pending(eng_pend)
  );

  assign stat_one_read = eng_sample && (eng_addr == PHY_STAT_ONE);

  // phy_status_one image
  always_comb begin
    stat_one = '0;
    stat_one[S1_FDPX_BIT] = 1'b1;
    stat_one[S1_HDPX_BIT] = 1'b1;
    stat_one[S1_LINK_BIT] = llink_ff;
    stat_one[S1_JAB_BIT] = ljab_ff;
  end

  // phy_status_two image, live bits are not latched
  always_comb begin
    stat_two = '0;
    stat_two[S2_TX_BIT] = PHY_TX_ACTIVE;
    stat_two[S2_RX_BIT] = PHY_RX_ACTIVE;
    stat_two[S2_COL_BIT] = COLLISION;
    stat_two[S2_LINK_BIT] = LINK_UP;
    stat_two[S2_DPX_BIT] = dpx_ff;
    stat_two[S2_POL_BIT] = RX_POL_INVERTED;
  end

  // phy register file as seen by the management engine
  always_comb begin
    eng_rd_in = '0;
    case (eng_addr)
      PHY_CTL_ONE: eng_rd_in[CTL1_DPX_BIT] = dpx_ff;
      PHY_STAT_ONE: eng_rd_in = stat_one;
      PHY_IDENT_HI: eng_rd_in = PHY_OUI_BITS[21:6];
      PHY_IDENT_LO: eng_rd_in = {PHY_OUI_BITS[5:0], PHY_PART, PHY_REV};
      PHY_STAT_TWO: eng_rd_in = stat_two;
      PHY_LED_CTL: eng_rd_in = led_ff;
      default: eng_rd_in = '0;
    endcase
  end

  // mgmt_status image, upper bits and reserved bit read zero
  always_comb begin
    mgmt_stat = '0;
    mgmt_stat[STAT_BUSY_BIT] = eng_busy || PHY_WR_BUSY;
    mgmt_stat[STAT_SCAN_BIT] = eng_scan;
    mgmt_stat[STAT_PEND_BIT] = eng_pend;
  end

  // next values of the control registers
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_sel = sel_ff;
    nxt_led = led_ff;
    nxt_dpx = dpx_ff;
    nxt_strap = 1'b0;
    if (hit(REG_WR, REG_ADDR, CTL_MGMT_CMD)) begin
      nxt_cmd = REG_WDATA[1:0];
    end
    if (hit(REG_WR, REG_ADDR, CTL_PHY_SEL)) begin
      nxt_sel = REG_WDATA[REG_AW-1:0];
    end
    if (hit(PHY_WR_STB, PHY_WR_ADDR, PHY_LED_CTL)) begin
      nxt_led = PHY_WR_DATA;
    end
    if (hit(PHY_WR_STB, PHY_WR_ADDR, PHY_CTL_ONE)) begin
      nxt_dpx = PHY_WR_DATA[CTL1_DPX_BIT];
    end
    // strap sets duplex
    // the strap is caught on the first edge after reset, over any write
    if (strap_ff) begin
      nxt_dpx = LED_B_STRAP;
    end
  end

  // next values of the latching status bits
  always_comb begin
    // one means always up
    // a read reloads from the live link, so a drop in that cycle still wins
    if (stat_one_read) begin
      nxt_llink = LINK_UP;
    end else begin
      nxt_llink = llink_ff && LINK_UP;
    end
    // jabber latches high
    // detection in the read cycle is kept for the next read
    nxt_ljab = (ljab_ff && !stat_one_read) || JABBER_DETECT;
  end

  // read data for the register port, answered one edge after the strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      case (REG_ADDR)
        CTL_MGMT_CMD: nxt_rdata = {6'h00, cmd_ff};
        CTL_PHY_SEL: nxt_rdata = {3'h0, sel_ff};
        CTL_RDATA_LO: nxt_rdata = eng_data[7:0];
        CTL_RDATA_HI: nxt_rdata = eng_data[15:8];
        CTL_MGMT_STAT: nxt_rdata = mgmt_stat;
        CTL_SIL_REV: nxt_rdata = {3'h0, SIL_REV};
        default: nxt_rdata = '0;
      endcase
    end
  end

  // register stage for all groups
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cmd_ff <= 2'h0;
      sel_ff <= '0;
      led_ff <= LED_CTL_RESET;
      dpx_ff <= 1'b0;
      strap_ff <= 1'b1;
      llink_ff <= 1'b0;
      ljab_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      cmd_ff <= nxt_cmd;
      sel_ff <= nxt_sel;
      led_ff <= nxt_led;
      dpx_ff <= nxt_dpx;
      strap_ff <= nxt_strap;
      llink_ff <= nxt_llink;
      ljab_ff <= nxt_ljab;
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign LED_CONTROL = led_ff;
  assign DUPLEX_STATE = dpx_ff;

  // checks on the behaviour above
  localparam int A_RD_MAX = READ_CYCLES;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence s_link_drop;
    !LINK_UP && !stat_one_read;
  endsequence
  sequence s_recover_no_read;
    (LINK_UP && !stat_one_read) [*3];
  endsequence

  a_single_read_done: assert property (
    start_single && !eng_busy |-> ##[1:A_RD_MAX] eng_sample)
    else $error("single read did not complete in time");
  a_scan_repeats: assert property (
    eng_sample ##1 cmd_ff[CMD_SCAN_BIT] |=> eng_busy && eng_scan)
    else $error("scan did not restart a read");
  a_pending_clear: assert property (
    eng_sample |=> !eng_pend && (eng_data == $past(eng_rd_in)))
    else $error("read data not stored or still pending");
  a_scan_status: assert property (
    $rose(cmd_ff[CMD_SCAN_BIT]) && !eng_busy |=> eng_scan && eng_busy)
    else $error("scan status not raised with scan");
  a_busy_status: assert property (
    REG_RD && REG_ADDR == CTL_MGMT_STAT |=>
      REG_RDATA[STAT_BUSY_BIT] == $past(eng_busy || PHY_WR_BUSY))
    else $error("busy status read wrong");
  a_link_holds_low: assert property (
    s_link_drop ##1 s_recover_no_read |=> !llink_ff)
    else $error("latched link recovered without a read");
  a_link_reload: assert property (
    stat_one_read && LINK_UP |=> llink_ff)
    else $error("latched link not reloaded on read");
  a_jabber_hold: assert property (
    JABBER_DETECT |=> ljab_ff ##1 (ljab_ff || $past(stat_one_read)))
    else $error("latched jabber lost before a read");
  a_capable_bits: assert property (
    eng_sample && eng_addr == PHY_STAT_ONE |=> eng_data[S1_FDPX_BIT] && eng_data[S1_HDPX_BIT])
    else $error("duplex capability bits not set");
  a_live_two: assert property (
    eng_sample && eng_addr == PHY_STAT_TWO |=>
      eng_data[S2_LINK_BIT] == $past(LINK_UP) && eng_data[S2_COL_BIT] == $past(COLLISION))
    else $error("live status bits not sampled");
  a_duplex_write: assert property (
    hit(PHY_WR_STB, PHY_WR_ADDR, PHY_CTL_ONE) && !strap_ff |=>
      DUPLEX_STATE == $past(PHY_WR_DATA[CTL1_DPX_BIT]))
    else $error("duplex state did not follow control write");
  a_duplex_strap: assert property (
    strap_ff && !SRST |=> DUPLEX_STATE == $past(LED_B_STRAP) && !strap_ff)
    else $error("duplex strap not captured");
  a_revision_read: assert property (
    REG_RD && REG_ADDR == CTL_SIL_REV |=> REG_RDATA == {3'h0, SIL_REV})
    else $error("silicon revision read wrong");
endmodule : pmsr_top

//--- tb/pmsr_phy_model.sv
`timescale 1ns/1ps
module pmsr_phy_model (
  // clock
  input wire logic clk,
  // wanted levels: link, tx, rx, collision, polarity, strap
  input wire logic [5:0] want,
  // one-cycle jabber event request
  input wire logic jab_req,
  // live phy levels toward the block
  output logic link_up,
  output logic jabber,
  output logic tx_on,
  output logic rx_on,
  output logic col_on,
  output logic pol_inv,
  output logic strap
);
  // levels move only just after an edge, so the block never sees a mid-cycle change
  always_ff @(posedge clk) begin
    {link_up, tx_on, rx_on, col_on, pol_inv, strap} <= want;
    // jabber is an event, not a level: it lasts one cycle only
    jabber <= jab_req;
  end
endmodule : pmsr_phy_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pmsr_pkg::*;
  localparam int RC = 8; // short read keeps the run brief
  localparam logic [21:0] OUI = 22'h2b3c4d; // arbitrary value
  localparam logic [5:0] PART = 6'h2a; // arbitrary value
  localparam logic [3:0] PREV = 4'h5; // arbitrary value
  localparam logic [4:0] SREV = 5'h13; // arbitrary value
  // bench-driven inputs
  logic clk, srst, reg_wr, reg_rd, phy_wr_stb, phy_wr_busy, jab_req;
  logic [4:0] reg_addr, phy_wr_addr;
  logic [7:0] reg_wdata, reg_rdata, s;
  logic [15:0] phy_wr_data, led_control, w;
  logic [5:0] want;
  // live phy levels from the partner
  logic link_up, jabber, tx_on, rx_on, col_on, pol_inv, strap, duplex_state;
  int error_cnt, n_checks, cyc;

  pmsr_phy_model u_pmsr_phy_model (.clk(clk), .want(want), .jab_req(jab_req),
    .link_up(link_up), .jabber(jabber), .tx_on(tx_on), .rx_on(rx_on), .col_on(col_on),
    .pol_inv(pol_inv), .strap(strap));

  pmsr_top #(.READ_CYCLES(RC), .PHY_OUI_BITS(OUI), .PHY_PART(PART), .PHY_REV(PREV),
    .SIL_REV(SREV)) u_pmsr_top (.CLOCK(clk), .SRST(srst), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .PHY_WR_STB(phy_wr_stb), .PHY_WR_ADDR(phy_wr_addr), .PHY_WR_DATA(phy_wr_data),
    .PHY_WR_BUSY(phy_wr_busy), .LINK_UP(link_up), .JABBER_DETECT(jabber),
    .PHY_TX_ACTIVE(tx_on), .PHY_RX_ACTIVE(rx_on), .COLLISION(col_on),
    .RX_POL_INVERTED(pol_inv), .LED_B_STRAP(strap), .LED_CONTROL(led_control),
    .DUPLEX_STATE(duplex_state));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // summary and verdict
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // single compare for every result, zero-extended to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // host register path
  // one-cycle write strobe on the register port
  task automatic reg_w(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_w

  // read strobe; data is settled the cycle after it is taken
  task automatic reg_r(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_r

  // poll until busy, scan and pending are all low, bounded
  task automatic wait_idle;
    int n;
    n = 0;
    reg_r(CTL_MGMT_STAT, s);
    while ((s[0] !== 1'b0 || s[1] !== 1'b0 || s[2] !== 1'b0) && n < 100) begin
      reg_r(CTL_MGMT_STAT, s);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      end_of_test();
    end
  endtask : wait_idle

  // single management read; the host waits for idle as it should
  task automatic phy_rd(input logic [4:0] a, output logic [15:0] d);
    reg_w(CTL_PHY_SEL, {3'h0, a});
    reg_w(CTL_MGMT_CMD, 8'h00);
    reg_w(CTL_MGMT_CMD, 8'h01);
    wait_idle();
    reg_r(CTL_RDATA_LO, d[7:0]);
    reg_r(CTL_RDATA_HI, d[15:8]);
    reg_w(CTL_MGMT_CMD, 8'h00);
  endtask : phy_rd

  // phy register write from the neighbouring write engine
  task automatic phy_w(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    phy_wr_stb <= 1'b1;
    phy_wr_addr <= a;
    phy_wr_data <= d;
    @(posedge clk);
    phy_wr_stb <= 1'b0;
    #1;
  endtask : phy_w

  // main sequence
  initial begin
    {srst, reg_wr, reg_rd, phy_wr_stb, phy_wr_busy, jab_req} = 6'b100000;
    {reg_addr, phy_wr_addr, reg_wdata, phy_wr_data} = '0;
    want = 6'b100001;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // reset values and read-only places
    reg_r(CTL_MGMT_STAT, s);
    chk({8'h00, s}, 16'h0000);
    reg_w(CTL_SIL_REV, 8'hff);
    reg_r(CTL_SIL_REV, s);
    chk({8'h00, s}, {11'h000, SREV});
    reg_r(5'h1f, s);
    chk({8'h00, s}, 16'h0000);
    reg_w(CTL_MGMT_CMD, 8'hfc);
    reg_r(CTL_MGMT_CMD, s);
    chk({8'h00, s}, 16'h0000);
    chk(led_control, 16'h3422);
    chk({15'h0, duplex_state}, 16'h0001);
    $display("test reset done");
    // identification words and single read
    phy_rd(PHY_IDENT_HI, w);
    chk(w, OUI[21:6]);
    phy_rd(PHY_IDENT_LO, w);
    chk(w, {OUI[5:0], PART, PREV});
    reg_w(CTL_MGMT_CMD, 8'h01);
    reg_r(CTL_MGMT_STAT, s);
    chk({8'h00, s}, 16'h0005);
    wait_idle();
    chk({8'h00, s}, 16'h0000);
    reg_w(CTL_MGMT_CMD, 8'h00);
    phy_wr_busy <= 1'b1;
    reg_r(CTL_MGMT_STAT, s);
    chk({8'h00, s}, 16'h0001);
    @(posedge clk) phy_wr_busy <= 1'b0;
    $display("test single read done");
    // latching link and jabber
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1800);
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1804);
    @(posedge clk) want <= 6'b000001;
    repeat (3) @(posedge clk);
    want <= 6'b100001;
    repeat (5) @(posedge clk);
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1800);
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1804);
    @(posedge clk) jab_req <= 1'b1;
    @(posedge clk) jab_req <= 1'b0;
    repeat (5) @(posedge clk);
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1806);
    phy_rd(PHY_STAT_ONE, w);
    chk(w, 16'h1804);
    $display("test latches done");
    // live status and duplex mirror
    want <= 6'b111111;
    phy_rd(PHY_STAT_TWO, w);
    chk(w, 16'h3e20);
    phy_w(PHY_CTL_ONE, 16'h0000);
    chk({15'h0, duplex_state}, 16'h0000);
    want <= 6'b000001;
    phy_rd(PHY_STAT_TWO, w);
    chk(w, 16'h0000);
    phy_w(PHY_CTL_ONE, 16'h0100);
    want <= 6'b001101;
    phy_rd(PHY_STAT_TWO, w);
    chk(w, 16'h1a00);
    phy_w(PHY_LED_CTL, 16'h0abc);
    chk(led_control, 16'h0abc);
    $display("test live status done");
    // continuous scan follows a changing condition
    reg_w(CTL_PHY_SEL, {3'h0, PHY_STAT_TWO});
    reg_w(CTL_MGMT_CMD, 8'h02);
    reg_r(CTL_MGMT_STAT, s);
    chk({8'h00, s}, 16'h0007);
    want <= 6'b110011;
    repeat (4 * (RC + 2)) @(posedge clk);
    reg_r(CTL_MGMT_STAT, s);
    chk({8'h00, s & 8'h06}, 16'h0002);
    reg_r(CTL_RDATA_HI, s);
    chk({8'h00, s}, 16'h0026);
    reg_r(CTL_RDATA_LO, s);
    chk({8'h00, s}, 16'h0020);
    reg_w(CTL_MGMT_CMD, 8'h00);
    wait_idle();
    chk({8'h00, s}, 16'h0000);
    $display("test scan done");
    end_of_test();
  end
endmodule : testbench
